/* logic/cprs_regs.sv */
`default_nettype none
module cprs_regs
  import cprs_pkg::*;
(
  // Clock, reset and freeze.
  input  wire logic          clk_sys,
  input  wire logic          reset,
  input  wire logic          clk_en,
  // Register port.
  input  wire cprs_bus_t     bus,
  output logic [DW-1:0]      rdata,
  // Operations from the sequencer.
  input  wire cprs_cmd_t     cmd,
  output logic               busy,
  // Interrupt inputs and outputs.
  input  wire logic          irq_latch,
  input  wire logic          timer_req,
  input  wire logic          instr_end,
  output logic               int_start,
  output logic               vector_fetch,
  // Memory-side addresses.
  output logic [15:0]        stack_addr,
  output logic               stack_strobe,
  output logic               stack_push,
  output logic [15:0]        operand_addr,
  output logic [15:0]        code_addr
);

  cprs_state_t s;
  cprs_state_t next_s;

  localparam cprs_state_t ST_RST = '{
    st: ST_IDLE, acc: 8'h00, idx: 8'h00, sp: SP_RESET, pc: PC_RESET,
    flg: FLG_RESET, cnt: 4'h0, push: 1'b0, entry: 1'b0, prod: 16'h0000,
    rdata: 16'h0000, stack_addr: 16'h0000, stack_strobe: 1'b0,
    vector_fetch: 1'b0, int_start: 1'b0, operand_addr: 16'h0000, busy: 1'b0};

  logic       irq_req;
  logic [7:0] opb;
  logic       cin;
  logic       is_sub;
  logic [8:0] sum9;
  logic [4:0] half5;
  logic [8:0] mstep;
  logic [5:0] sp_dn;
  logic [5:0] sp_up;

  assign irq_req = irq_latch | timer_req;
  // Subtract is the adder fed with the inverted operand and carry in.
  assign is_sub  = (cmd.code == OP_SUB) || (cmd.code == OP_SBC);
  assign opb     = is_sub ? ~cmd.operand : cmd.operand;
  assign sum9    = {1'b0, s.acc} + {1'b0, opb} + {8'h00, cin};
  assign half5   = {1'b0, s.acc[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
  assign mstep   = {1'b0, s.prod[15:8]} + {1'b0, (s.prod[0] ? s.idx : 8'h00)};
  // Only the six low bits move, so deep nesting silently wraps.
  assign sp_dn   = s.sp[5:0] - 6'h01;
  assign sp_up   = s.sp[5:0] + 6'h01;

  always_comb begin
    case (cmd.code)
      OP_ADC:  cin = s.flg[FLG_C];
      OP_SUB:  cin = 1'b1;
      OP_SBC:  cin = ~s.flg[FLG_C];
      default: cin = 1'b0;
    endcase
  end

  always_comb begin
    next_s              = s;
    next_s.stack_strobe = 1'b0;
    next_s.vector_fetch = 1'b0;
    next_s.int_start    = 1'b0;
    case (s.st)
      ST_IDLE: begin
        next_s.int_start = instr_end & irq_req & ~s.flg[FLG_I];
        case (cmd.idx_mode)
          IDX_NONE:  next_s.operand_addr = {8'h00, s.idx};
          IDX_OFF8:  next_s.operand_addr = {8'h00, s.idx} + {8'h00, cmd.disp[7:0]};
          IDX_OFF16: next_s.operand_addr = {8'h00, s.idx} + cmd.disp;
          default:   next_s.operand_addr = {8'h00, s.idx};
        endcase
        if (cmd.valid) begin
          case (cmd.code)
            OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
              next_s.acc = sum9[7:0];
              next_s.flg[FLG_C] = is_sub ? ~sum9[8] : sum9[8];
              if (!is_sub) begin
                next_s.flg[FLG_H] = half5[4];
              end
              next_s.flg[FLG_N] = sum9[7];
              next_s.flg[FLG_Z] = (sum9[7:0] == 8'h00);
            end
            OP_AND, OP_ORA, OP_EOR, OP_LDA: begin
              case (cmd.code)
                OP_AND:  next_s.acc = s.acc & cmd.operand;
                OP_ORA:  next_s.acc = s.acc | cmd.operand;
                OP_EOR:  next_s.acc = s.acc ^ cmd.operand;
                default: next_s.acc = cmd.operand;
              endcase
              next_s.flg[FLG_N] = next_s.acc[7];
              next_s.flg[FLG_Z] = (next_s.acc == 8'h00);
            end
            OP_LDX: begin
              next_s.idx = cmd.operand;
              next_s.flg[FLG_N] = cmd.operand[7];
              next_s.flg[FLG_Z] = (cmd.operand == 8'h00);
            end
            OP_ASL, OP_LSR, OP_ROL, OP_ROR: begin
              case (cmd.code)
                OP_ASL:  next_s.acc = {s.acc[6:0], 1'b0};
                OP_LSR:  next_s.acc = {1'b0, s.acc[7:1]};
                OP_ROL:  next_s.acc = {s.acc[6:0], s.flg[FLG_C]};
                default: next_s.acc = {s.flg[FLG_C], s.acc[7:1]};
              endcase
              next_s.flg[FLG_C] = (cmd.code == OP_ASL || cmd.code == OP_ROL) ?
                                  s.acc[7] : s.acc[0];
              next_s.flg[FLG_N] = next_s.acc[7];
              next_s.flg[FLG_Z] = (next_s.acc == 8'h00);
            end
            OP_BTST: next_s.flg[FLG_C] = cmd.operand[cmd.disp[2:0]];
            OP_PUSH, OP_CALL, OP_INTENT: begin
              next_s.st    = ST_STACK;
              next_s.push  = 1'b1;
              next_s.entry = (cmd.code == OP_INTENT);
              next_s.cnt   = (cmd.code == OP_PUSH) ? 4'h1 :
                             (cmd.code == OP_CALL) ? CALL_BYTES : INT_BYTES;
              next_s.busy  = 1'b1;
            end
            OP_PULL, OP_IRET: begin
              next_s.st    = ST_STACK;
              next_s.push  = 1'b0;
              next_s.entry = 1'b0;
              next_s.cnt   = (cmd.code == OP_PULL) ? 4'h1 : INT_BYTES;
              next_s.busy  = 1'b1;
              if (cmd.code == OP_IRET) begin
                next_s.flg = cmd.operand[4:0];
              end
            end
            OP_REINIT: next_s.sp = SP_RESET;
            OP_FETCH:  next_s.pc = s.pc + 13'h0001;
            OP_JUMP:   next_s.pc = cmd.disp[12:0];
            OP_CLI:    next_s.flg[FLG_I] = 1'b0;
            OP_SEI:    next_s.flg[FLG_I] = 1'b1;
            OP_MUL: begin
              next_s.st   = ST_MUL;
              next_s.cnt  = 4'h0;
              next_s.prod = {8'h00, s.acc};
              next_s.busy = 1'b1;
            end
            default: ;
          endcase
        end
      end
      ST_MUL: begin
        // One shift-add per cycle keeps the adder to eight bits wide.
        next_s.cnt = s.cnt + 4'h1;
        if (s.cnt < MUL_STEPS) begin
          next_s.prod = {mstep, s.prod[7:1]};
        end
        if (s.cnt == MUL_LAST) begin
          next_s.idx        = s.prod[15:8];
          next_s.acc        = s.prod[7:0];
          next_s.flg[FLG_H] = 1'b0;
          next_s.flg[FLG_C] = 1'b0;
          next_s.st         = ST_IDLE;
          next_s.busy       = 1'b0;
        end
      end
      ST_STACK: begin
        next_s.stack_strobe = 1'b1;
        if (s.push) begin
          next_s.stack_addr = {3'b000, SP_FIXED, s.sp[5:0]};
          next_s.sp         = {SP_FIXED, sp_dn};
        end else begin
          next_s.stack_addr = {3'b000, SP_FIXED, sp_up};
          next_s.sp         = {SP_FIXED, sp_up};
        end
        next_s.cnt = s.cnt - 4'h1;
        if (s.cnt == 4'h1) begin
          next_s.st   = s.entry ? ST_VECTOR : ST_IDLE;
          next_s.busy = s.entry;
        end
      end
      ST_VECTOR: begin
        // The mask is raised only once every byte of state is stacked.
        next_s.flg[FLG_I]   = 1'b1;
        next_s.vector_fetch = 1'b1;
        next_s.entry        = 1'b0;
        next_s.st           = ST_IDLE;
        next_s.busy         = 1'b0;
      end
      default: begin
        next_s = ST_RST;
      end
    endcase
    if (bus.wr) begin
      case (bus.addr)
        REG_ACC:   next_s.acc = bus.wdata[7:0];
        REG_INDEX: next_s.idx = bus.wdata[7:0];
        REG_STACK: next_s.sp  = {SP_FIXED, bus.wdata[5:0]};
        REG_IPTR:  next_s.pc  = bus.wdata[12:0];
        // The mask bit is kept: software clears it only through an operation.
        REG_FLAGS: next_s.flg = {bus.wdata[4], s.flg[FLG_I], bus.wdata[2:0]};
        default: ;
      endcase
    end
    if (bus.rd) begin
      case (bus.addr)
        REG_ACC:    next_s.rdata = {8'h00, s.acc};
        REG_INDEX:  next_s.rdata = {8'h00, s.idx};
        REG_STACK:  next_s.rdata = {3'b000, SP_FIXED, s.sp[5:0]};
        REG_IPTR:   next_s.rdata = {3'b000, s.pc};
        REG_FLAGS:  next_s.rdata = {8'h00, FLG_UPPER, s.flg};
        REG_STATUS: next_s.rdata = {13'h0000, irq_req & s.flg[FLG_I], s.int_start,
                                    s.busy};
        default:    next_s.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s <= ST_RST;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  assign rdata        = s.rdata;
  assign busy         = s.busy;
  assign int_start    = s.int_start;
  assign vector_fetch = s.vector_fetch;
  assign stack_addr   = s.stack_addr;
  assign stack_strobe = s.stack_strobe;
  assign stack_push   = s.push;
  assign operand_addr = s.operand_addr;
  assign code_addr    = {3'b000, s.pc};

  stack_range_a: assert property (@(posedge clk_sys) disable iff (reset)
    stack_strobe |-> stack_addr[15:6] == 10'h003)
    else $error("stack address outside its page");
  flag_upper_a: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && bus.rd && bus.addr == REG_FLAGS) |=> rdata[7:5] == 3'b111)
    else $error("flag register upper bits not one");
  masked_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && s.flg[FLG_I]) |=> !int_start)
    else $error("interrupt started while masked");
  int_take_a: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && s.st == ST_IDLE && instr_end && irq_req && !s.flg[FLG_I]) |=> int_start)
    else $error("pending unmasked interrupt not started");
  vector_mask_a: assert property (@(posedge clk_sys) disable iff (reset)
    vector_fetch |-> (s.flg[FLG_I] && $past(stack_strobe)))
    else $error("vector fetch without mask after pushes");
  mul_end_a: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && s.st == ST_MUL && s.cnt == MUL_LAST) |=> !busy)
    else $error("multiply did not end on its last cycle");
  mul_busy_a: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && s.st == ST_IDLE && cmd.valid && cmd.code == OP_MUL) |=> busy[*2])
    else $error("multiply not busy after start");
  pc_step_a: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && s.st == ST_IDLE && cmd.valid && cmd.code == OP_FETCH && !bus.wr)
      |=> code_addr[12:0] == $past(code_addr[12:0]) + 13'h0001)
    else $error("instruction pointer did not advance by one");
  sp_reinit_a: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && s.st == ST_IDLE && cmd.valid && cmd.code == OP_REINIT && !bus.wr)
      |=> s.sp == SP_RESET)
    else $error("stack pointer not reinitialised");
  index_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
    (clk_en && s.st == ST_IDLE && cmd.idx_mode == IDX_NONE)
      |=> operand_addr == {8'h00, $past(s.idx)})
    else $error("unoffset indexed address wrong");

endmodule : cprs_regs
`default_nettype wire

/* logic/cprs_pkg.sv */
`default_nettype none
package cprs_pkg;
  localparam int          DW         = 16;
  localparam logic [3:0]  REG_ACC    = 4'h0;
  localparam logic [3:0]  REG_INDEX  = 4'h1;
  localparam logic [3:0]  REG_STACK  = 4'h2;
  localparam logic [3:0]  REG_IPTR   = 4'h3;
  localparam logic [3:0]  REG_FLAGS  = 4'h4;
  localparam logic [3:0]  REG_STATUS = 4'h5;
  localparam int          FLG_C      = 0;
  localparam int          FLG_Z      = 1;
  localparam int          FLG_N      = 2;
  localparam int          FLG_I      = 3;
  localparam int          FLG_H      = 4;
  localparam logic [4:0]  FLG_RESET  = 5'h08;
  localparam logic [2:0]  FLG_UPPER  = 3'h7;
  localparam logic [12:0] SP_RESET   = 13'h00ff;
  localparam logic [6:0]  SP_FIXED   = 7'h03;
  localparam logic [12:0] PC_RESET   = 13'h0000;
  localparam logic [3:0]  MUL_CYCLES = 4'hb;
  localparam logic [3:0]  MUL_LAST   = MUL_CYCLES - 4'h2;
  localparam logic [3:0]  MUL_STEPS  = 4'h8;
  localparam logic [3:0]  CALL_BYTES = 4'h2;
  localparam logic [3:0]  INT_BYTES  = 4'h5;

  typedef enum logic [1:0] {
    IDX_NONE = 2'h0,
    IDX_OFF8 = 2'h1,
    IDX_OFF16 = 2'h2
  } cprs_idx_t;

  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_ORA, OP_EOR,
    OP_LDA, OP_LDX, OP_ASL, OP_LSR, OP_ROL, OP_ROR, OP_BTST,
    OP_PUSH, OP_PULL, OP_CALL, OP_INTENT, OP_IRET, OP_REINIT,
    OP_FETCH, OP_JUMP, OP_CLI, OP_SEI, OP_MUL
  } cprs_op_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_MUL    = 4'h2,
    ST_STACK  = 4'h4,
    ST_VECTOR = 4'h8
  } cprs_st_t;

  typedef struct packed {
    logic [3:0]    addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } cprs_bus_t;

  typedef struct packed {
    logic       valid;
    cprs_op_t   code;
    logic [7:0] operand;
    logic [15:0] disp;
    cprs_idx_t  idx_mode;
  } cprs_cmd_t;

  typedef struct packed {
    cprs_st_t      st;
    logic [7:0]    acc;
    logic [7:0]    idx;
    logic [12:0]   sp;
    logic [12:0]   pc;
    logic [4:0]    flg;
    logic [3:0]    cnt;
    logic          push;
    logic          entry;
    logic [15:0]   prod;
    logic [DW-1:0] rdata;
    logic [15:0]   stack_addr;
    logic          stack_strobe;
    logic          vector_fetch;
    logic          int_start;
    logic [15:0]   operand_addr;
    logic          busy;
  } cprs_state_t;
endpackage : cprs_pkg
`default_nettype wire

/* testbench/tb.sv */
`default_nettype none
module tb
  import cprs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic          clk_sys;
  logic          reset;
  logic          clk_en;
  logic          irq_latch;
  logic          timer_req;
  logic          instr_end;
  cprs_bus_t     bus;
  cprs_cmd_t     cmd;
  logic [DW-1:0] rdata;
  logic          busy;
  logic          int_start;
  logic          vector_fetch;
  logic          stack_strobe;
  logic          stack_push;
  logic [15:0]   stack_addr;
  logic [15:0]   operand_addr;
  logic [15:0]   code_addr;
  int            mismatches;
  int            tests_run;
  int            n_int;
  int            n_vec;
  int            nb;
  logic [16:0]   sq[$];
  logic [15:0]   v;

  cprs_regs cprs_regs_i (
    .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .bus(bus), .rdata(rdata),
    .cmd(cmd), .busy(busy), .irq_latch(irq_latch), .timer_req(timer_req),
    .instr_end(instr_end), .int_start(int_start), .vector_fetch(vector_fetch),
    .stack_addr(stack_addr), .stack_strobe(stack_strobe), .stack_push(stack_push),
    .operand_addr(operand_addr), .code_addr(code_addr)
  );

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Strobes count once per high cycle, and int_start stays high while an unmasked request stands with instr_end high;
  // they are collected mid-cycle so that a check at the next rising edge already sees them.
  always @(negedge clk_sys) begin
    if (stack_strobe === 1'b1) sq.push_back({stack_push, stack_addr});
    if (int_start === 1'b1) n_int++;
    if (vector_fetch === 1'b1) n_vec++;
  end

  task finish_test;
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test

  task chk(input string nm, input logic [16:0] e, input logic [16:0] g);
    tests_run++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask : chk

  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a, output logic [15:0] r);
    @(posedge clk_sys);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    // The answer stands for this whole cycle and is taken at its closing edge.
    @(posedge clk_sys);
    r = rdata;
  endtask : rd

  task rchk(input string nm, input logic [3:0] a, input logic [15:0] e);
    logic [15:0] r;
    rd(a, r);
    chk(nm, e, r);
  endtask : rchk

  // Returns in nb the number of cycles busy stayed high after the accept edge.
  task op(input cprs_op_t c, input logic [7:0] o, input logic [15:0] d);
    @(posedge clk_sys);
    cmd <= '{1'b1, c, o, d, IDX_NONE};
    @(posedge clk_sys);
    cmd.valid <= 1'b0;
    nb = 0;
    @(posedge clk_sys);
    while (busy !== 1'b0 && nb < 40) begin
      nb++;
      @(posedge clk_sys);
    end
    if (nb == 40) chk("busy", 16'h0000, 16'h0001);
  endtask : op

  task stk(input logic p, input logic [7:0] first, input int n, input int dir);
    chk("strobes", 16'(n), 16'(sq.size()));
    for (int i = 0; i < n && i < sq.size(); i++)
      chk("stack", {p, 8'h00, 8'(first + dir * i)}, sq[i]);
    sq.delete();
  endtask : stk

  task idx(input cprs_idx_t m, input logic [15:0] d, input logic [15:0] e);
    @(posedge clk_sys);
    cmd <= '{1'b0, OP_NOP, 8'h00, d, m};
    repeat (2) @(posedge clk_sys);
    chk("operand_addr", e, operand_addr);
  endtask : idx

  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    irq_latch = 1'b0;
    timer_req = 1'b0;
    instr_end = 1'b0;
    bus = '0;
    cmd = '{1'b0, OP_NOP, 8'h00, 16'h0000, IDX_NONE};
    mismatches = 0;
    tests_run = 0;
    n_int = 0;
    n_vec = 0;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    rchk("flags", REG_FLAGS, 16'h00e8);
    rchk("sp", REG_STACK, 16'h00ff);
    rchk("unmapped", 4'h9, 16'h0000);
    chk("code_addr", 16'h0000, code_addr);
    wr(REG_FLAGS, 16'h0000);
    rchk("flags", REG_FLAGS, 16'h00e8);
    wr(REG_ACC, 16'h005a);
    rchk("acc", REG_ACC, 16'h005a);
    // With the clock enable low a write must not land.
    clk_en <= 1'b0;
    wr(REG_ACC, 16'h0033);
    clk_en <= 1'b1;
    rchk("frozen acc", REG_ACC, 16'h005a);
    wr(REG_ACC, 16'h000f);
    op(OP_ADD, 8'h01, 16'h0000);
    rchk("acc", REG_ACC, 16'h0010);
    rchk("flags", REG_FLAGS, 16'h00f8);
    wr(REG_ACC, 16'h0080);
    op(OP_ADD, 8'h80, 16'h0000);
    rchk("flags", REG_FLAGS, 16'h00eb);
    op(OP_LDA, 8'h80, 16'h0000);
    rd(REG_FLAGS, v);
    chk("neg", 16'h0004, v & 16'h0006);
    wr(REG_ACC, 16'h00ff);
    op(OP_ADD, 8'h01, 16'h0000);
    rchk("flags", REG_FLAGS, 16'h00fb);
    op(OP_ADC, 8'h00, 16'h0000);
    rchk("acc", REG_ACC, 16'h0001);
    rchk("flags", REG_FLAGS, 16'h00e8);
    wr(REG_ACC, 16'h0005);
    op(OP_SUB, 8'h07, 16'h0000);
    rchk("acc", REG_ACC, 16'h00fe);
    rchk("flags", REG_FLAGS, 16'h00ed);
    wr(REG_ACC, 16'h0081);
    op(OP_ASL, 8'h00, 16'h0000);
    rchk("acc", REG_ACC, 16'h0002);
    rd(REG_FLAGS, v);
    chk("carry", 16'h0001, v & 16'h0001);
    op(OP_BTST, 8'hfb, 16'h0002);
    rd(REG_FLAGS, v);
    chk("carry", 16'h0000, v & 16'h0001);
    op(OP_BTST, 8'h04, 16'h0002);
    rd(REG_FLAGS, v);
    chk("carry", 16'h0001, v & 16'h0001);
    wr(REG_INDEX, 16'h00f0);
    idx(IDX_NONE, 16'h1234, 16'h00f0);
    idx(IDX_OFF8, 16'h0020, 16'h0110);
    idx(IDX_OFF16, 16'h1234, 16'h1324);
    wr(REG_ACC, 16'h00ff);
    wr(REG_INDEX, 16'h00ff);
    op(OP_MUL, 8'h00, 16'h0000);
    chk("mul cycles", 16'd10, 16'(nb));
    rchk("acc", REG_ACC, 16'h0001);
    rchk("index", REG_INDEX, 16'h00fe);
    rd(REG_FLAGS, v);
    chk("mul flags", 16'h0000, v & 16'h0011);
    op(OP_FETCH, 8'h00, 16'h0000);
    rchk("iptr", REG_IPTR, 16'h0001);
    op(OP_JUMP, 8'h00, 16'h1fff);
    rchk("iptr", REG_IPTR, 16'h1fff);
    chk("code_addr", 16'h1fff, code_addr);
    op(OP_FETCH, 8'h00, 16'h0000);
    rchk("iptr", REG_IPTR, 16'h0000);
    // Mask set: a standing request must not start entry.
    irq_latch <= 1'b1;
    instr_end <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk("masked int", 16'h0000, 16'(n_int));
    rd(REG_STATUS, v);
    chk("pending", 16'h0004, v & 16'h0004);
    op(OP_CLI, 8'h00, 16'h0000);
    repeat (3) @(posedge clk_sys);
    chk("unmasked int", 16'h0001, 16'(n_int > 0));
    irq_latch <= 1'b0;
    timer_req <= 1'b1;
    n_int = 0;
    repeat (3) @(posedge clk_sys);
    chk("timer int", 16'h0001, 16'(n_int > 0));
    instr_end <= 1'b0;
    repeat (2) @(posedge clk_sys);
    n_int = 0;
    repeat (3) @(posedge clk_sys);
    chk("no end", 16'h0000, 16'(n_int));
    timer_req <= 1'b0;
    op(OP_REINIT, 8'h00, 16'h0000);
    sq.delete();
    op(OP_INTENT, 8'h00, 16'h0000);
    chk("vector", 16'h0001, 16'(vector_fetch));
    stk(1'b1, 8'hff, 5, -1);
    rchk("flags", REG_FLAGS, 16'h00e8);
    rchk("sp", REG_STACK, 16'h00fa);
    op(OP_CALL, 8'h00, 16'h0000);
    stk(1'b1, 8'hfa, 2, -1);
    op(OP_IRET, 8'h00, 16'h0000);
    stk(1'b0, 8'hf9, 5, 1);
    rchk("flags", REG_FLAGS, 16'h00e0);
    rchk("sp", REG_STACK, 16'h00fd);
    op(OP_REINIT, 8'h00, 16'h0000);
    rchk("sp", REG_STACK, 16'h00ff);
    op(OP_PULL, 8'h00, 16'h0000);
    stk(1'b0, 8'hc0, 1, 1);
    op(OP_PUSH, 8'h00, 16'h0000);
    stk(1'b1, 8'hc0, 1, 1);
    rchk("sp", REG_STACK, 16'h00ff);
    chk("vectors", 16'h0001, 16'(n_vec));
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    finish_test();
  end
endmodule : tb
`default_nettype wire
